// file: led_status_pkg.sv
// Purpose: shared constants and carriers for the network status indicator driver
// Assumes: system clock of 20 MHz
// Notes: blink half periods are derived from the clock rate and the blink rate
package led_status_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 20_000_000;
    localparam int ACT_BLINK_HZ = 10; // activity blink rate
    localparam int COL_BLINK_HZ = 20; // collision blink rate
    // half period in cycles; exact at 20 MHz, integer division rounds down
    localparam int ACT_HALF_CYC = CLK_HZ / (2 * ACT_BLINK_HZ);
    localparam int COL_HALF_CYC = CLK_HZ / (2 * COL_BLINK_HZ);

    // ------------------------------------------------------------
    // pin sampling and reset values
    // ------------------------------------------------------------
    localparam int PIN_W = 3; // power detects plus arrangement strap
    localparam int PIN_AUX = 0;
    localparam int PIN_MAIN = 1;
    localparam int PIN_MODE = 2;
    localparam logic [2:0] PIN_RST = 3'h0;
    localparam logic [3:0] LED_RST = 4'h0; // all indicators dark

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic link_up;     // good link
        logic speed_100;   // 1 = 100 Mbit/s, 0 = 10 Mbit/s
        logic full_duplex; // full duplex configuration
        logic rx_active;   // valid receive traffic
        logic tx_active;   // valid transmit traffic
        logic collision;   // collision seen
    } net_status_s;

    typedef struct packed {
        logic duplex_collision_indicator; // fourth pin
        logic high_speed_indicator;       // third pin
        logic low_speed_indicator;        // second pin
        logic activity_indicator;         // first pin
    } led_out_s;

endpackage

// file: blink_prescaler.sv
// Purpose: free-running divider giving a 50 percent duty square wave
// Assumes: single clock, synchronous active-low reset
// Notes: wave starts low after reset and toggles every HALF_CYC cycles
`timescale 1ns/100ps
`default_nettype none
module blink_prescaler #(
    parameter int HALF_CYC = 1000
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    output var logic wave
);
    localparam int CW = $clog2(HALF_CYC + 1);
    localparam logic [CW-1:0] LAST = CW'(HALF_CYC - 1);

    logic [CW-1:0] cnt_r, cnt_nxt;
    logic wave_r, wave_nxt;

    // ------------------------------------------------------------
    // divider
    // ------------------------------------------------------------
    // free running so blink phase never depends on traffic timing
    always_comb begin
        cnt_nxt = cnt_r + CW'(1);
        wave_nxt = wave_r;
        if (cnt_r == LAST) begin
            cnt_nxt = '0;
            wave_nxt = ~wave_r;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cnt_r <= '0;
            wave_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            wave_r <= wave_nxt;
        end
    end

    assign wave = wave_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_toggle_at_wrap;
        @(posedge clk_sys) disable iff (!rst_n)
        (cnt_r == LAST) |=> (wave_r != $past(wave_r)) && (cnt_r == '0);
    endproperty
    a_toggle_at_wrap: assert property (p_toggle_at_wrap) else $error("wave did not toggle at wrap");

    property p_hold_between;
        @(posedge clk_sys) disable iff (!rst_n)
        (cnt_r != LAST) |=> $stable(wave_r);
    endproperty
    a_hold_between: assert property (p_hold_between) else $error("wave toggled mid period");

endmodule
`default_nettype wire

// file: net_led_driver.sv
// Purpose: network status indicator driver with power detect sampling
// Assumes: status inputs come from logic on clk_sys; strap and power pins are asynchronous
// Notes: outputs are active high (1 = lamp on); mode strap is static in use
`timescale 1ns/100ps
`default_nettype none
module net_led_driver #(
    parameter int ACT_HALF_CYC = led_status_pkg::ACT_HALF_CYC,
    parameter int COL_HALF_CYC = led_status_pkg::COL_HALF_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire led_status_pkg::net_status_s net_status,
    input wire logic four_led_mode_pin,
    input wire logic aux_power_pin,
    input wire logic main_power_pin,
    output var led_status_pkg::led_out_s leds,
    output var logic aux_power_present,
    output var logic main_power_present
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [led_status_pkg::PIN_W-1:0] pin_meta_r, pin_meta_nxt;
    logic [led_status_pkg::PIN_W-1:0] pin_sync_r, pin_sync_nxt;
    logic live_r, live_nxt;

    // first stage feeds only the second stage
    // live_r masks the release edge: reset is sampled there but disable iff already sees it gone
    always_comb begin
        pin_meta_nxt = {four_led_mode_pin, main_power_pin, aux_power_pin};
        pin_sync_nxt = pin_meta_r;
        live_nxt = 1'b1;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pin_meta_r <= led_status_pkg::PIN_RST;
            pin_sync_r <= led_status_pkg::PIN_RST;
            live_r <= 1'b0;
        end else begin
            pin_meta_r <= pin_meta_nxt;
            pin_sync_r <= pin_sync_nxt;
            live_r <= live_nxt;
        end
    end

    logic four_mode;
    assign four_mode = pin_sync_r[led_status_pkg::PIN_MODE];

    // power detects are reported straight from the second stage
    assign aux_power_present = pin_sync_r[led_status_pkg::PIN_AUX];
    assign main_power_present = pin_sync_r[led_status_pkg::PIN_MAIN];

    // ------------------------------------------------------------
    // blink sources
    // ------------------------------------------------------------
    logic act_wave;
    logic col_wave;

    blink_prescaler #(
        .HALF_CYC(ACT_HALF_CYC)
    ) u_act_blink (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .wave(act_wave)
    );

    blink_prescaler #(
        .HALF_CYC(COL_HALF_CYC)
    ) u_col_blink (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .wave(col_wave)
    );

    // ------------------------------------------------------------
    // lamp decode
    // ------------------------------------------------------------
    logic traffic;
    logic dup_col;
    logic speed_10_on;
    logic speed_100_on;
    led_status_pkg::led_out_s leds_r, leds_nxt;

    // speed lamps need a link, otherwise a dead port would show a speed
    always_comb begin
        traffic = net_status.rx_active | net_status.tx_active;
        speed_10_on = net_status.link_up & ~net_status.speed_100;
        speed_100_on = net_status.link_up & net_status.speed_100;
        if (net_status.full_duplex) begin
            dup_col = 1'b1;
        end else if (net_status.collision) begin
            dup_col = col_wave;
        end else begin
            dup_col = 1'b0;
        end
        leds_nxt = led_status_pkg::LED_RST;
        if (four_mode) begin
            leds_nxt.activity_indicator = traffic & act_wave;
            leds_nxt.low_speed_indicator = speed_10_on;
            leds_nxt.high_speed_indicator = speed_100_on;
            leds_nxt.duplex_collision_indicator = dup_col;
        end else begin
            // traffic blink overrides the steady link lamp
            leds_nxt.activity_indicator = traffic ? act_wave : net_status.link_up;
            leds_nxt.low_speed_indicator = dup_col;
            leds_nxt.high_speed_indicator = speed_100_on;
            leds_nxt.duplex_collision_indicator = 1'b0;
        end
    end

    // registered so the pins never glitch on decode hazards
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            leds_r <= led_status_pkg::LED_RST;
        end else begin
            leds_r <= leds_nxt;
        end
    end

    assign leds = leds_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n || !live_r);

    property p_act_blink;
        four_mode && (net_status.rx_active || net_status.tx_active)
            |=> leds.activity_indicator == $past(act_wave);
    endproperty
    a_act_blink: assert property (p_act_blink) else $error("activity lamp not following blink");

    property p_act_dark;
        four_mode && !net_status.rx_active && !net_status.tx_active |=> !leds.activity_indicator;
    endproperty
    a_act_dark: assert property (p_act_dark) else $error("activity lamp lit without traffic");

    property p_link_steady;
        !four_mode && net_status.link_up && !net_status.rx_active && !net_status.tx_active
            |=> leds.activity_indicator;
    endproperty
    a_link_steady: assert property (p_link_steady) else $error("link lamp not steady");

    property p_link_blink;
        !four_mode && (net_status.rx_active || net_status.tx_active)
            |=> leds.activity_indicator == $past(act_wave);
    endproperty
    a_link_blink: assert property (p_link_blink) else $error("link lamp not blinking on traffic");

    property p_low_speed;
        four_mode |=> leds.low_speed_indicator == $past(net_status.link_up && !net_status.speed_100);
    endproperty
    a_low_speed: assert property (p_low_speed) else $error("low speed lamp wrong");

    property p_high_speed;
        four_mode |=> leds.high_speed_indicator == $past(net_status.link_up && net_status.speed_100);
    endproperty
    a_high_speed: assert property (p_high_speed) else $error("high speed lamp wrong");

    property p_speed_three;
        !four_mode && net_status.link_up |=> leds.high_speed_indicator == $past(net_status.speed_100);
    endproperty
    a_speed_three: assert property (p_speed_three) else $error("three-mode speed lamp wrong");

    property p_full_duplex;
        net_status.full_duplex |=> (four_mode ? leds.duplex_collision_indicator : leds.low_speed_indicator)
            || ($past(four_mode) != four_mode);
    endproperty
    a_full_duplex: assert property (p_full_duplex) else $error("duplex lamp not steady");

    property p_collision;
        four_mode && !net_status.full_duplex && net_status.collision
            |=> leds.duplex_collision_indicator == $past(col_wave);
    endproperty
    a_collision: assert property (p_collision) else $error("collision lamp not blinking");

    property p_aux_follow;
        aux_power_pin ##1 aux_power_pin |=> aux_power_present;
    endproperty
    a_aux_follow: assert property (p_aux_follow) else $error("aux power not reported");

    property p_main_lost;
        !main_power_pin ##1 !main_power_pin |=> !main_power_present;
    endproperty
    a_main_lost: assert property (p_main_lost) else $error("main power loss not reported");

    property p_fourth_dark;
        !four_mode |=> !leds.duplex_collision_indicator;
    endproperty
    a_fourth_dark: assert property (p_fourth_dark) else $error("fourth lamp lit in three-output mode");

    property p_reset_dark;
        @(posedge clk_sys) disable iff (1'b0)
        !rst_n |=> (leds == led_status_pkg::LED_RST) && !aux_power_present && !main_power_present;
    endproperty
    a_reset_dark: assert property (p_reset_dark) else $error("outputs not cleared by reset");

    c_four_traffic: cover property (four_mode && net_status.rx_active ##1 leds.activity_indicator);
    c_three_link: cover property (!four_mode && net_status.link_up ##1 leds.activity_indicator);
    c_collision: cover property (net_status.collision && !net_status.full_duplex ##1 leds.low_speed_indicator);
    c_power_loss: cover property (main_power_present ##1 !main_power_present);

endmodule
`default_nettype wire

// file: lamp_rail_model.sv
// Purpose: far side of the indicator driver: lamps and board power rails
// Assumes: rails change only just after a rising clock edge
// Notes: lamps are passive loads, so only their lit time is tallied
`timescale 1ns/100ps
`default_nettype none
module lamp_rail_model (
    input wire logic clk_sys,
    input wire led_status_pkg::led_out_s leds,
    input wire logic aux_req,
    input wire logic main_req,
    output var logic aux_power_pin,
    output var logic main_power_pin,
    output var int lamp_on_cycles
);
    // start levels come from the declarations so each pin keeps a single driver
    logic aux_q = 1'b0;
    logic main_q = 1'b0;
    int tally = 0;

    // rails follow the request one edge late, like a switched supply
    always @(posedge clk_sys) begin
        aux_q <= aux_req;
        main_q <= main_req;
        tally <= tally + $countones(leds);
    end

    assign aux_power_pin = aux_q;
    assign main_power_pin = main_q;
    assign lamp_on_cycles = tally;
endmodule
`default_nettype wire

// file: net_led_driver_tb.sv
// Purpose: self-checking bench for the network status indicator driver
// Assumes: short blink half periods so many blink cycles fit in the run
// Notes: a cycle-exact reference runs beside the design and is compared every cycle
`timescale 1ns/100ps
`default_nettype none
module net_led_driver_tb;
    localparam int ACT_H = 8;
    localparam int COL_H = 4;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    led_status_pkg::net_status_s net_status = '0;
    logic four_led_mode_pin = 1'b1;
    logic aux_req = 1'b0;
    logic main_req = 1'b0;
    logic aux_power_pin;
    logic main_power_pin;
    led_status_pkg::led_out_s leds;
    led_status_pkg::led_out_s leds_exp_r;
    logic aux_power_present;
    logic main_power_present;
    logic [1:0] mode_r;
    logic [1:0] aux_r;
    logic [1:0] main_r;
    logic act_w_r;
    logic col_w_r;
    logic armed = 1'b0;
    int act_cnt_r;
    int col_cnt_r;
    int n_mismatch = 0;
    int compares = 0;
    int lamp_on_cycles;
    int lamp_exp = 0;

    always #25 clk_sys = ~clk_sys;

    net_led_driver #(.ACT_HALF_CYC(ACT_H), .COL_HALF_CYC(COL_H)) DUT (
        .clk_sys(clk_sys), .rst_n(rst_n), .net_status(net_status),
        .four_led_mode_pin(four_led_mode_pin), .aux_power_pin(aux_power_pin),
        .main_power_pin(main_power_pin), .leds(leds),
        .aux_power_present(aux_power_present), .main_power_present(main_power_present)
    );

    lamp_rail_model far_side (
        .clk_sys(clk_sys), .leds(leds), .aux_req(aux_req), .main_req(main_req),
        .aux_power_pin(aux_power_pin), .main_power_pin(main_power_pin), .lamp_on_cycles(lamp_on_cycles)
    );

    // ------------------------------------------------------------
    // reference model
    // ------------------------------------------------------------
    function automatic led_status_pkg::led_out_s exp_leds(input led_status_pkg::net_status_s s,
            input logic four, input logic aw, input logic cw);
        led_status_pkg::led_out_s o;
        logic traffic;
        logic dc;
        traffic = s.rx_active | s.tx_active;
        dc = s.full_duplex ? 1'b1 : (s.collision ? cw : 1'b0);
        if (four) begin
            o = {dc, s.link_up & s.speed_100, s.link_up & ~s.speed_100, traffic ? aw : 1'b0};
        end else begin
            // fourth lamp dark, duplex moves to the second pin
            o = {1'b0, s.link_up & s.speed_100, dc, traffic ? aw : s.link_up};
        end
        return o;
    endfunction

    // waves start low at count zero on every reset release
    always @(posedge clk_sys) begin
        armed <= 1'b1;
        lamp_exp <= lamp_exp + $countones(leds_exp_r); // same edges the far side tallies on
        if (!rst_n) begin
            {mode_r, aux_r, main_r, act_w_r, col_w_r} <= '0;
            act_cnt_r <= 0;
            col_cnt_r <= 0;
            leds_exp_r <= led_status_pkg::LED_RST;
        end else begin
            mode_r <= {mode_r[0], four_led_mode_pin};
            aux_r <= {aux_r[0], aux_power_pin};
            main_r <= {main_r[0], main_power_pin};
            act_cnt_r <= (act_cnt_r == ACT_H - 1) ? 0 : act_cnt_r + 1;
            col_cnt_r <= (col_cnt_r == COL_H - 1) ? 0 : col_cnt_r + 1;
            act_w_r <= act_w_r ^ (act_cnt_r == ACT_H - 1);
            col_w_r <= col_w_r ^ (col_cnt_r == COL_H - 1);
            leds_exp_r <= exp_leds(net_status, mode_r[1], act_w_r, col_w_r);
        end
    end

    // ------------------------------------------------------------
    // checking and closing
    // ------------------------------------------------------------
    task automatic check(input logic [3:0] got, input logic [3:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // sample mid-cycle, where every registered output has settled
    always @(negedge clk_sys) begin
        if (armed) begin
            check(leds, leds_exp_r);
            check({aux_power_present, main_power_present}, {aux_r[1], main_r[1]});
        end
    end

    task automatic end_of_test();
        compares++;
        if (lamp_on_cycles != lamp_exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t lamp tally got=%h exp=%h", $time, lamp_on_cycles, lamp_exp);
        end
        $display("compares=%0d mismatches=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // status held for random runs so blinking is really seen on the lamps
    task automatic run(input int n, input logic mode, input logic [5:0] mask, input logic [5:0] val);
        int i;
        int hold;
        logic [5:0] st;
        four_led_mode_pin <= mode;
        for (i = 0; i < n; i += hold) begin
            hold = $urandom_range(16, 1);
            st = (6'($urandom()) & ~mask) | (val & mask);
            net_status <= led_status_pkg::net_status_s'(st);
            aux_req <= 1'($urandom());
            main_req <= 1'($urandom());
            repeat (hold) @(posedge clk_sys);
        end
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32598));
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        run(300, 1'b1, 6'h00, 6'h00);
        $display("test four-output random done");
        run(300, 1'b0, 6'h00, 6'h00);
        $display("test three-output random done");
        run(60, 1'b1, 6'h3f, 6'h01);
        run(60, 1'b0, 6'h3f, 6'h06);
        run(60, 1'b1, 6'h3f, 6'h39);
        run(60, 1'b1, 6'h3f, 6'h24);
        $display("test corner cases done");
        rst_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        run(100, 1'b1, 6'h00, 6'h00);
        $display("test mid-run reset done");
        end_of_test();
    end

    // the run needs about 1000 cycles; allow a wide margin
    initial begin
        #(50 * 4000);
        n_mismatch++;
        $display("[ERR] t=%0t watchdog expired got=%h exp=%h", $time, 1'b0, 1'b1);
        end_of_test();
    end
endmodule
`default_nettype wire
